//--- rtl/rts_supervisor.sv
module rts_supervisor #(
    parameter int READ_W = rts_pkg::READ_W,
    parameter logic [1:0] FSW_FACTORY = rts_pkg::FSW_DEFAULT
) (
    input wire logic ref_clk, // 200 MHz clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic [READ_W-1:0] thermistorInput, // Thermistor reading (async)
    input wire logic batteryTempMonitorDisable, // Monitor disable bit
    input wire logic [1:0] reverseHotThreshold, // Shared hot limit code
    input wire logic reverseColdThreshold, // Shared cold limit code
    input wire logic chargeIndicatorDisable, // Charge indicator disable bit
    input wire logic reverseIndicatorEnable, // Reverse indicator enable bit
    input wire logic reverseActive, // Reverse mode selected (async)
    input wire logic chargeActive, // Charge mode selected (async)
    input wire logic chargeInProgress, // Charging not complete (async)
    input wire logic reverseOutputValid, // Reverse output in regulation (async)
    input wire logic reverseFault, // Reverse fault (async)
    input wire logic reverseLightLoad, // Light-load shutdown (async)
    input wire logic [2:0] reverseStateIn, // Reverse machine state from core
    output logic reverseResetForce, // Force reverse machine to reset state
    output logic tempOutOfRange, // Temperature outside window
    output logic [1:0] switchFreqSel, // Switching frequency code
    output logic chargeStatusPinOut, // Open-drain data, always low
    output logic chargeStatusPinOe // Low while pulling pin low
);
    // Hot limit rises in fixed steps with the code; a reading below it is too hot
    function automatic logic [READ_W-1:0] hotLimit(input logic [1:0] code);
        logic [READ_W-1:0] step;
        step = READ_W'(rts_pkg::HOT_STEP);
        case (code)
            2'h0: hotLimit = READ_W'(rts_pkg::HOT_BASE);
            2'h1: hotLimit = READ_W'(rts_pkg::HOT_BASE) + step;
            2'h2: hotLimit = READ_W'(rts_pkg::HOT_BASE) + (step << 1);
            default: hotLimit = READ_W'(rts_pkg::HOT_BASE) + (step << 1) + step;
        endcase
    endfunction : hotLimit

    // A reading above the cold limit is too cold
    function automatic logic [READ_W-1:0] coldLimit(input logic code);
        if (code) begin
            coldLimit = READ_W'(rts_pkg::COLD_FAR);
        end else begin
            coldLimit = READ_W'(rts_pkg::COLD_NEAR);
        end
    endfunction : coldLimit

    // Two-flop synchronisers for asynchronous inputs
    localparam int NS = 6;
    logic [NS-1:0] s1_q, s1_d, s2_q, s2_d;
    logic [READ_W-1:0] t1_q, t1_d, t2_q, t2_d;
    logic revA, chgA, chgProg, outValid, fault, lightLoad;

    always_comb begin
        s1_d = {reverseActive, chargeActive, chargeInProgress,
                reverseOutputValid, reverseFault, reverseLightLoad};
        s2_d = s1_q;
        t1_d = thermistorInput;
        t2_d = t1_q;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            // Mid-range value so a fresh reset never reports a false hot or cold reading
            t1_q <= READ_W'(rts_pkg::TEMP_IDLE);
            t2_q <= READ_W'(rts_pkg::TEMP_IDLE);
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            t1_q <= t1_d;
            t2_q <= t2_d;
        end
    end

    assign {revA, chgA, chgProg, outValid, fault, lightLoad} = s2_q;

    // A multi-bit reading may be caught mid-change by the synchroniser; a sample is
    // taken only once two consecutive words agree, at the cost of two extra cycles
    logic [READ_W-1:0] t3_q, t3_d, tempSample_q, tempSample_d;
    logic readingSteady;

    always_comb begin
        t3_d = t2_q;
        readingSteady = (t2_q == t3_q);
        tempSample_d = tempSample_q;
        if (readingSteady) begin
            tempSample_d = t3_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            t3_q <= READ_W'(rts_pkg::TEMP_IDLE);
            tempSample_q <= READ_W'(rts_pkg::TEMP_IDLE);
        end else begin
            t3_q <= t3_d;
            tempSample_q <= tempSample_d;
        end
    end

    // Temperature supervision
    logic oor_q, oor_d, force_q, force_d, monOn;
    logic [1:0] fsw_q, fsw_d;

    always_comb begin
        monOn = !batteryTempMonitorDisable; // R02
        // Thresholds are the shared non-JEITA limit inputs, no local copy kept
        oor_d = monOn && ((tempSample_q < hotLimit(reverseHotThreshold)) ||
                (tempSample_q > coldLimit(reverseColdThreshold))); // R03 R04
        force_d = revA && oor_d; // R01
        fsw_d = FSW_FACTORY; // R05
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            oor_q <= 1'b0;
            force_q <= 1'b0;
            fsw_q <= FSW_FACTORY;
        end else begin
            oor_q <= oor_d;
            force_q <= force_d;
            fsw_q <= fsw_d;
        end
    end

    assign tempOutOfRange = oor_q;
    assign reverseResetForce = force_q;
    assign switchFreqSel = fsw_q;

    // Status pin: only ever drives low, so the data bit is constant zero
    logic oe_q, oe_d, pullLow;

    always_comb begin
        pullLow = 1'b0; // R11
        if (revA) begin
            if (reverseIndicatorEnable) begin // R08
                pullLow = outValid && !fault && !lightLoad &&
                    (reverseStateIn == 3'(rts_pkg::REV_REGULATE)); // R10
            end
        end else if (chgA) begin
            if (!chargeIndicatorDisable) begin // R07
                pullLow = chgProg; // R09
            end
        end
        oe_d = !pullLow; // R06
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            oe_q <= 1'b1;
        end else begin
            oe_q <= oe_d;
        end
    end

    assign chargeStatusPinOe = oe_q;

    // Data bit kept in a flop as well, so every output leaves a register
    logic pinOut_q, pinOut_d;

    always_comb begin
        pinOut_d = 1'b0; // R06
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pinOut_q <= 1'b0;
        end else begin
            pinOut_q <= pinOut_d;
        end
    end

    assign chargeStatusPinOut = pinOut_q;

    // Assertions
    force_needs_rev_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R01
        reverseResetForce
        |-> $past(revA) && $past(monOn))
        else $error("reset forced outside reverse mode or monitor off");

    force_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R01
        (revA && oor_d)
        |=> reverseResetForce)
        else $error("reset not forced while temperature out of window");

    force_release_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R01
        (revA && !oor_d)
        |=> !reverseResetForce)
        else $error("reset forced with temperature in window");

    force_rev_only_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R01
        !revA
        |=> !reverseResetForce)
        else $error("reset forced outside reverse mode");

    disable_clears_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R02
        batteryTempMonitorDisable ##1 batteryTempMonitorDisable
        |-> !tempOutOfRange)
        else $error("out of range flagged while monitoring disabled");

    mon_off_force_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R02
        batteryTempMonitorDisable
        |=> !reverseResetForce)
        else $error("reset forced while monitoring disabled");

    oor_needs_mon_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R02
        tempOutOfRange
        |-> $past(monOn))
        else $error("out of range flagged without monitoring");

    hot_compare_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R03
        (!batteryTempMonitorDisable && tempSample_q < hotLimit(reverseHotThreshold))
        |=> tempOutOfRange)
        else $error("hot limit crossing missed");

    cold_compare_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R03
        (!batteryTempMonitorDisable && tempSample_q > coldLimit(reverseColdThreshold))
        |=> tempOutOfRange)
        else $error("cold limit crossing missed");

    in_window_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R03
        (tempSample_q >= hotLimit(reverseHotThreshold) &&
        tempSample_q <= coldLimit(reverseColdThreshold))
        |=> !tempOutOfRange)
        else $error("out of range flagged inside window");

    sample_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R03
        !readingSteady
        |=> $stable(tempSample_q))
        else $error("reading sampled while still changing");

    sample_take_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R03
        readingSteady
        |=> tempSample_q == $past(t3_q))
        else $error("steady reading not sampled");

    fsw_fixed_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R05
        ##1
        switchFreqSel == FSW_FACTORY)
        else $error("switching frequency not factory value");

    reset_values_a: assert property (@(posedge ref_clk) // R05
        !rst_n
        |=> chargeStatusPinOe && !reverseResetForce && switchFreqSel == FSW_FACTORY)
        else $error("outputs not at reset values");

    pin_low_only_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R06
        1'b1
        |-> chargeStatusPinOut == 1'b0)
        else $error("status pin driven high");

    chg_disable_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R07
        (chgA && !revA && chargeIndicatorDisable)
        |=> chargeStatusPinOe)
        else $error("pin pulled while charge indicator disabled");

    rev_disable_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R08
        (revA && !reverseIndicatorEnable)
        |=> chargeStatusPinOe)
        else $error("pin pulled while reverse indicator disabled");

    rev_ignores_chg_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R08
        (revA && chgProg && !chargeIndicatorDisable && !reverseIndicatorEnable)
        |=> chargeStatusPinOe)
        else $error("charge state shown in reverse mode");

    chg_progress_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R09
        (chgA && !revA && !chargeIndicatorDisable)
        |=> chargeStatusPinOe == !$past(chgProg))
        else $error("charge pin state wrong");

    chg_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R09
        (chgA && !revA && !chargeIndicatorDisable && chgProg)
        |=> !chargeStatusPinOe)
        else $error("pin not pulled while charging");

    chg_done_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R09
        (chgA && !revA && !chgProg)
        |=> chargeStatusPinOe)
        else $error("pin pulled after charging complete");

    rev_fault_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R10
        (revA && (fault || lightLoad || !outValid))
        |=> chargeStatusPinOe)
        else $error("pin pulled in reverse fault");

    rev_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R10
        (revA && reverseIndicatorEnable && outValid && !fault && !lightLoad &&
        reverseStateIn == 3'(rts_pkg::REV_REGULATE))
        |=> !chargeStatusPinOe)
        else $error("pin not pulled with reverse output valid");

    rev_state_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R10
        (revA && reverseStateIn != 3'(rts_pkg::REV_REGULATE))
        |=> chargeStatusPinOe)
        else $error("pin pulled outside regulation");

    pin_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R11
        (!revA && !chgA)
        |=> chargeStatusPinOe)
        else $error("pin pulled with no mode active");
endmodule : rts_supervisor

//--- rtl/rts_pkg.sv
// Summary of operation
// R01 - Out-of-window temperature in reverse mode forces reverse state machine to reset state.
// R02 - Reverse temperature monitoring runs only while the monitor disable bit is zero.
// R03 - Thermistor reading compared to two-bit hot field and cold field of config 0x1D.
// R04 - Reverse thresholds share storage with non-JEITA charging temperature limits.
// R05 - Reverse switching frequency equals charging frequency, factory set, not user writable.
// R06 - Status pin is open drain: pulls low or releases; outside party supplies pull-up.
// R07 - Charge mode: indicator active when charge indicator disable bit (0x00) is zero.
// R08 - Reverse mode: indicator active when reverse indicator enable bit (0x0F) is one.
// R09 - Charge mode active: pin low while charging, released when charging complete.
// R10 - Reverse mode active: pin low only when output enabled and valid, else released.
// R11 - Indicator disabled for present mode holds the pin released regardless of state.
package rts_pkg;
    localparam logic [7:0] CFG_TEMP_ADDR = 8'h1D;
    localparam logic [7:0] CFG_CHG_ADDR = 8'h00;
    localparam logic [7:0] CFG_REV_ADDR = 8'h0F;
    localparam int HOT_W = 2;
    localparam int READ_W = 12;
    localparam logic [11:0] HOT_BASE = 12'h400;
    localparam logic [11:0] HOT_STEP = 12'h100;
    localparam logic [11:0] COLD_NEAR = 12'hB00;
    localparam logic [11:0] COLD_FAR = 12'hC00;
    localparam logic [11:0] TEMP_IDLE = 12'h800;
    localparam logic [1:0] FSW_DEFAULT = 2'h2;
    localparam int SYNC_STAGES = 2;
    typedef enum logic [1:0] {
        FSW_125K,
        FSW_250K,
        FSW_500K,
        FSW_1M
    } rts_fsw_t;
    typedef enum logic [2:0] {
        REV_RESET,
        REV_SOFTSTART,
        REV_REGULATE,
        REV_HICCUP,
        REV_LIGHTLOAD
    } rts_rev_t;
endpackage : rts_pkg

//--- verif/rts_led_model.sv
// Status indicator on the far side: a pull-up brings the line high whenever it is released
module rts_led_model (
    input wire logic pinOut, // Open-drain data from the block
    input wire logic pinOe, // Low while the block pulls the line
    output logic pinLevel // Resolved line level
);
    timeunit 1ns;
    timeprecision 1ps;
    assign pinLevel = !pinOe ? pinOut : 1'b1;
endmodule : rts_led_model

//--- verif/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, rst_n = 0, monDis = 1, cold = 0, chgDis = 0, revEn = 0, revAct = 0;
    logic chgAct = 0, chgProg = 0, revValid = 0, revFault = 0, revLl = 0;
    logic [1:0] hot = 0, fsw;
    logic [2:0] revState = 0;
    logic [11:0] tempCode = 12'h800;
    logic rstForce, oor, pinOut, pinOe, pinLevel;
    int badCount = 0, checked = 0;
    rts_supervisor dut (.ref_clk(ref_clk), .rst_n(rst_n), .thermistorInput(tempCode),
        .batteryTempMonitorDisable(monDis), .reverseHotThreshold(hot),
        .reverseColdThreshold(cold), .chargeIndicatorDisable(chgDis),
        .reverseIndicatorEnable(revEn), .reverseActive(revAct), .chargeActive(chgAct),
        .chargeInProgress(chgProg), .reverseOutputValid(revValid), .reverseFault(revFault),
        .reverseLightLoad(revLl), .reverseStateIn(revState), .reverseResetForce(rstForce),
        .tempOutOfRange(oor), .switchFreqSel(fsw), .chargeStatusPinOut(pinOut),
        .chargeStatusPinOe(pinOe));
    rts_led_model led (.pinOut(pinOut), .pinOe(pinOe), .pinLevel(pinLevel));
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    task check(input logic [11:0] seen, input logic [11:0] exp);
        if (seen !== exp) begin
            badCount++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
        checked++;
    endtask : check
    // Reading needs two sync edges, a steady check, the sample and the output register
    task settle;
        repeat (6) @(negedge ref_clk);
    endtask : settle
    task stopTest;
        $display("comparisons %0d, mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : stopTest
    initial begin
        repeat (2) @(negedge ref_clk);
        rst_n = 1;
        @(negedge ref_clk);
        check(fsw, rts_pkg::FSW_DEFAULT);
        check(pinLevel, 1);
        check(pinOut, 0);
        $display("test reset done");
        chgAct = 1; chgProg = 1; settle; check(pinLevel, 0);
        chgDis = 1; settle; check(pinLevel, 1);
        chgDis = 0; chgProg = 0; settle; check(pinLevel, 1);
        $display("test charge done");
        chgAct = 0; revAct = 1; revEn = 1; revValid = 1; revState = 3'h2;
        settle; check(pinLevel, 0);
        revFault = 1; settle; check(pinLevel, 1);
        revFault = 0; revState = 3'h3; settle; check(pinLevel, 1);
        revState = 3'h2; revLl = 1; settle; check(pinLevel, 1);
        revLl = 0; revEn = 0; settle; check(pinLevel, 1);
        $display("test reverse pin done");
        monDis = 0;
        for (int c = 0; c < 4; c++) begin
            hot = c[1:0];
            tempCode = 12'h3FF + 12'h100 * c[11:0];
            settle; check(rstForce, 1);
            tempCode = tempCode + 12'h1;
            settle; check(rstForce, 0);
        end
        tempCode = 12'hB01; settle; check(rstForce, 1);
        cold = 1; settle; check(rstForce, 0);
        cold = 0; monDis = 1; settle; check(rstForce, 0);
        monDis = 0; revAct = 0; settle; check(rstForce, 0);
        check(oor, 1);
        $display("test temperature done");
        stopTest;
    end
    initial begin
        #20us;
        badCount++;
        stopTest;
    end
endmodule : tb
